/* slp_ctrl.sv */
// Control logic of a three-loop synthesizer with APB register access
//
// Summary of operation
// RL1: Two-bit gain code scales gain: 00 full, 01 half, 10 quarter, 11 eighth.
// RL2: Host picks gain codes from each loop's N value range.
// RL3: First 13 update periods self-tune, then the loop controls frequency.
// RL4: Settling ends after 40 periods, or 100 us at fast update rates.
// RL5: RF output follows the RF loop whose R or N was last written.
// RL6: Low-bias bit set reduces IF amplifier bias; clear keeps full output.
// RL7: Powerdown pin low turns IF and RF off regardless of registers.
// RL8: Pin high, auto clear: each section follows its power enable bit.
// RL9: Pin high, auto set: both sections on, enable bits ignored.
// RL10: Reference amplifier is on when either power enable is high.
// RL11: Register writes are accepted in every power state.
// RL12: Aux pin shows the selected signal; code 011 gives lock warning. Only the lock warning code is decoded; other codes drive the pin low.
// RL13: Lock warning high while tuning or near range limit, else low; the aux pin drives it inverted, low while warning.
// RL14: Self-tune starts at loop power-up or on frequency change.
// RL15: Phase counters advance once per reference-divided-by-R period.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps

module slp_ctrl
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input slp_pkg::slp_apb_req_t apb_req,
  output slp_pkg::slp_apb_rsp_t apb_rsp,
  // Device pins
  input wire logic powerdown_pin_n,
  input wire logic reference_input_pin,
  input wire logic [2:0] comp_limit_near,
  output logic aux_output_pin,
  // Analog controls
  output slp_pkg::slp_power_t power_ctl,
  output logic if_low_bias,
  output logic rf_vco_select,
  output logic [1:0] rf1_pd_gain,
  output logic [1:0] rf2_pd_gain,
  output logic [1:0] if_pd_gain,
  output logic [2:0][3:0] pd_rel_gain,
  // Loop status
  output logic [2:0] loop_in_control,
  output logic [2:0] loop_settled,
  output logic lock_warning_n,
  // Interrupt
  output logic irq
);
  import slp_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [SLP_NREG-1:0][17:0] regs;
    slp_loop_t [SLP_NLOOP-1:0] loop;
    logic ref_d;
    logic ref_half;
    logic rf_sel;
    logic lockw;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [31:0] rdata;
    slp_power_t pwr;
    logic aux;
    logic irq;
  } slp_state_t;

  slp_state_t q;
  slp_state_t nxt_q;
  logic addr_ok;
  logic [31:0] rd_val;

  // ----------------------------------------------------------------------
  // Address decode and read mux
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [5:0] ridx;
    ridx = apb_req.paddr[7:2];
    addr_ok = 1'b1;
    rd_val = 32'h00000000;
    if (apb_req.paddr[1:0] != 2'h0)
    begin
      addr_ok = 1'b0;
    end
    else if (ridx < 6'(SLP_NREG))
    begin
      rd_val = {14'h0000, q.regs[ridx[3:0]]};
    end
    else if (ridx == SLP_IDX_IRQ_STAT)
    begin
      rd_val = {28'h0000000, q.irq_stat};
    end
    else if (ridx == SLP_IDX_IRQ_MASK)
    begin
      rd_val = {28'h0000000, q.irq_mask};
    end
    else if (ridx == SLP_IDX_LOOP_STAT)
    begin
      rd_val = {25'h0000000, ~q.lockw, q.loop[2].phase,
                q.loop[1].phase, q.loop[0].phase};
    end
    else
    begin
      addr_ok = 1'b0;
    end
  end

  // Zero wait states; unmapped or unaligned addresses answer with error
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~addr_ok;
  assign apb_rsp.prdata = q.rdata;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic wr;
    logic [5:0] idx;
    logic ref_tick;
    logic [2:0] freq_wr;
    logic [2:0] pw;
    logic [2:0] settle_ev;
    logic [3:0] clr;
    logic upd;
    logic tune_any;
    logic near_any;
    logic if_en;
    logic rf_en;
    logic [12:0] rval;
    nxt_q = q;
    wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    idx = apb_req.paddr[7:2];
    freq_wr = 3'h0;
    settle_ev = 3'h0;
    clr = 4'h0;
    upd = 1'b0;
    tune_any = 1'b0;
    near_any = 1'b0;
    rval = 13'h0000;
    ref_tick = 1'b0;
    pw = 3'h0;
    if_en = 1'b0;
    rf_en = 1'b0;

    // Read data is captured in the setup cycle
    if (apb_req.psel && !apb_req.penable)
    begin
      nxt_q.rdata = rd_val;
    end

    // Writes are never gated by the power state [RL11]
    if (wr && addr_ok)
    begin
      if (idx < 6'(SLP_NREG))
      begin
        nxt_q.regs[idx[3:0]] = apb_req.pwdata[17:0] &
                               SLP_WMASK[idx[3:0]];
      end
      if (idx == SLP_IDX_N_RF1 || idx == SLP_IDX_R_RF1)
      begin
        freq_wr[0] = 1'b1;
        nxt_q.rf_sel = 1'b0; // [RL5]
      end
      else if (idx == SLP_IDX_N_RF2 || idx == SLP_IDX_R_RF2)
      begin
        freq_wr[1] = 1'b1;
        nxt_q.rf_sel = 1'b1; // [RL5]
      end
      else if (idx == SLP_IDX_N_IF || idx == SLP_IDX_R_IF)
      begin
        freq_wr[2] = 1'b1;
      end
      else if (idx == SLP_IDX_IRQ_STAT)
      begin
        clr = apb_req.pwdata[3:0];
      end
      else if (idx == SLP_IDX_IRQ_MASK)
      begin
        nxt_q.irq_mask = apb_req.pwdata[3:0];
      end
    end

    // Reference edge, optionally halved, feeds every R divider
    nxt_q.ref_d = reference_input_pin;
    nxt_q.ref_half = q.ref_half ^ (reference_input_pin & ~q.ref_d);
    ref_tick = reference_input_pin & ~q.ref_d &
               (~q.regs[SLP_IDX_MAIN][SLP_XDIV2_BIT] | q.ref_half);

    // Pin overrides all; auto forces both on; else enable bits
    if_en = powerdown_pin_n &
            (q.regs[SLP_IDX_MAIN][SLP_AUTO_BIT] |
             q.regs[SLP_IDX_PWR][SLP_IFPWR_BIT]); // [RL7] [RL8] [RL9]
    rf_en = powerdown_pin_n &
            (q.regs[SLP_IDX_MAIN][SLP_AUTO_BIT] |
             q.regs[SLP_IDX_PWR][SLP_RFPWR_BIT]); // [RL7] [RL8] [RL9]
    nxt_q.pwr.if_on = if_en;
    nxt_q.pwr.rf_on = rf_en;
    nxt_q.pwr.ref_on = if_en | rf_en; // [RL10]
    pw = {if_en, rf_en, rf_en};

    // Per-loop self-tune and settling sequencer
    for (int i = 0; i < SLP_NLOOP; i++)
    begin
      upd = 1'b0;
      rval = q.regs[SLP_IDX_R_RF1 + 6'(i)][SLP_RLSB_BITS-1:0];
      nxt_q.loop[i].pwr = pw[i];
      if (!pw[i])
      begin
        nxt_q.loop[i].phase = SLP_OFF;
        nxt_q.loop[i].rcnt = 13'h0000;
        nxt_q.loop[i].pcnt = 6'h00;
        nxt_q.loop[i].cyc = 12'h000;
      end
      else if (!q.loop[i].pwr || freq_wr[i])
      begin
        // Restart tuning at power-up or frequency change [RL14]
        nxt_q.loop[i].phase = SLP_TUNE;
        nxt_q.loop[i].rcnt = 13'h0000;
        nxt_q.loop[i].pcnt = 6'h00;
        nxt_q.loop[i].cyc = 12'h000;
        nxt_q.loop[i].pmeas = 7'h00;
        nxt_q.loop[i].fast = 1'b0;
      end
      else
      begin
        // Update period from reference divided by R; R of 0 acts as 1
        if (ref_tick)
        begin
          if (q.loop[i].rcnt + 13'h0001 >= rval)
          begin
            nxt_q.loop[i].rcnt = 13'h0000;
            upd = 1'b1; // [RL15]
          end
          else
          begin
            nxt_q.loop[i].rcnt = q.loop[i].rcnt + 13'h0001;
          end
        end
        // Measure the period to spot update rates above the limit
        if (upd)
        begin
          nxt_q.loop[i].fast = q.loop[i].pmeas < SLP_FAST_PERIOD_CYC;
          nxt_q.loop[i].pmeas = 7'h00;
        end
        else if (q.loop[i].pmeas != 7'h7F)
        begin
          nxt_q.loop[i].pmeas = q.loop[i].pmeas + 7'h01;
        end
        if (q.loop[i].cyc != 12'hFFF)
        begin
          nxt_q.loop[i].cyc = q.loop[i].cyc + 12'h001;
        end
        if (upd && q.loop[i].phase != SLP_LOCK)
        begin
          nxt_q.loop[i].pcnt = q.loop[i].pcnt + 6'h01; // [RL15]
        end
        case (q.loop[i].phase)
          SLP_TUNE:
          begin
            if (upd && q.loop[i].pcnt + 6'h01 == SLP_TUNE_PERIODS)
            begin
              nxt_q.loop[i].phase = SLP_SETTLE; // [RL3]
            end
          end
          SLP_SETTLE:
          begin
            if ((upd && q.loop[i].pcnt + 6'h01 == SLP_SETTLE_PERIODS) ||
                (q.loop[i].fast && q.loop[i].cyc >= SLP_SETTLE_MAX_CYC))
            begin
              nxt_q.loop[i].phase = SLP_LOCK; // [RL4]
              settle_ev[i] = 1'b1;
            end
          end
          default:
          begin
          end
        endcase
      end
      tune_any = tune_any | (q.loop[i].phase == SLP_TUNE);
      near_any = near_any |
                 (comp_limit_near[i] & (q.loop[i].phase != SLP_OFF));
    end

    // Lock warning while tuning or near the compensation limit
    nxt_q.lockw = tune_any | near_any; // [RL13]

    // Sticky events; a new event wins over a clear in the same cycle
    nxt_q.irq_stat = (q.irq_stat & ~clr) |
                     {nxt_q.lockw & ~q.lockw, settle_ev};
    nxt_q.irq = |(nxt_q.irq_stat & nxt_q.irq_mask);

    // Aux pin source; other select codes drive low
    nxt_q.aux = ~q.lockw & // [RL12]
                (q.regs[SLP_IDX_MAIN][SLP_AUX_SEL_LSB +: 2] ==
                 SLP_AUX_LOCK);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '0;
    end
    else
    begin
      q <= nxt_q;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Per-loop gain scaling and status
  for (genvar g = 0; g < SLP_NLOOP; g++)
  begin : gen_loop
    assign pd_rel_gain[g] =
      SLP_GAIN_FULL >> q.regs[SLP_IDX_GAIN][2*g +: 2]; // [RL1]
    assign loop_in_control[g] = q.loop[g].phase == SLP_SETTLE ||
                                q.loop[g].phase == SLP_LOCK; // [RL3]
    assign loop_settled[g] = q.loop[g].phase == SLP_LOCK;
  end

  // Register-driven controls
  assign rf1_pd_gain = q.regs[SLP_IDX_GAIN][1:0];
  assign rf2_pd_gain = q.regs[SLP_IDX_GAIN][3:2];
  assign if_pd_gain = q.regs[SLP_IDX_GAIN][5:4];
  assign if_low_bias = q.regs[SLP_IDX_MAIN][SLP_LOWBIAS_BIT]; // [RL6]
  assign rf_vco_select = q.rf_sel; // [RL5]
  assign power_ctl = q.pwr;
  assign lock_warning_n = ~q.lockw;
  assign aux_output_pin = q.aux;
  assign irq = q.irq;

endmodule

/* slp_pkg.sv */
// Package: register map, timing constants and types of the loop control
package slp_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte address = 4 * index)
  // ----------------------------------------------------------------------
  localparam int SLP_NLOOP = 3;
  localparam int SLP_NREG = 9;
  localparam logic [5:0] SLP_IDX_MAIN = 6'h00;
  localparam logic [5:0] SLP_IDX_GAIN = 6'h01;
  localparam logic [5:0] SLP_IDX_PWR = 6'h02;
  localparam logic [5:0] SLP_IDX_N_RF1 = 6'h03;
  localparam logic [5:0] SLP_IDX_N_RF2 = 6'h04;
  localparam logic [5:0] SLP_IDX_N_IF = 6'h05;
  localparam logic [5:0] SLP_IDX_R_RF1 = 6'h06;
  localparam logic [5:0] SLP_IDX_R_RF2 = 6'h07;
  localparam logic [5:0] SLP_IDX_R_IF = 6'h08;
  localparam logic [5:0] SLP_IDX_IRQ_STAT = 6'h10;
  localparam logic [5:0] SLP_IDX_IRQ_MASK = 6'h11;
  localparam logic [5:0] SLP_IDX_LOOP_STAT = 6'h12;
  // Writable bits of each register, index 8 first
  localparam logic [SLP_NREG-1:0][17:0] SLP_WMASK = {
    18'h01FFF, 18'h01FFF, 18'h01FFF, 18'h0FFFF, 18'h1FFFF,
    18'h3FFFF, 18'h00003, 18'h0003F, 18'h03C68};
  localparam logic [17:0] SLP_REG_RST = 18'h00000;

  // ----------------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------------
  localparam int SLP_AUX_SEL_LSB = 12;
  localparam int SLP_XDIV2_BIT = 6;
  localparam int SLP_LOWBIAS_BIT = 5;
  localparam int SLP_AUTO_BIT = 3;
  localparam int SLP_IFPWR_BIT = 1;
  localparam int SLP_RFPWR_BIT = 0;
  localparam int SLP_RLSB_BITS = 13;
  localparam logic [1:0] SLP_AUX_LOCK = 2'h3;
  localparam logic [3:0] SLP_GAIN_FULL = 4'h8;
  localparam int SLP_IRQ_LOCKW_BIT = 3;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int SLP_CLK_HZ = 40000000;
  localparam logic [5:0] SLP_TUNE_PERIODS = 6'h0D;
  localparam logic [5:0] SLP_SETTLE_PERIODS = 6'h28;
  localparam int SLP_FAST_RATE_HZ = 500000;
  localparam int SLP_SETTLE_MAX_US = 100;
  localparam logic [11:0] SLP_SETTLE_MAX_CYC =
    12'(SLP_SETTLE_MAX_US * (SLP_CLK_HZ / 1000000));
  localparam logic [6:0] SLP_FAST_PERIOD_CYC =
    7'(SLP_CLK_HZ / SLP_FAST_RATE_HZ);

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SLP_OFF = 2'b00,
    SLP_TUNE = 2'b01,
    SLP_SETTLE = 2'b10,
    SLP_LOCK = 2'b11
  } slp_phase_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } slp_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } slp_apb_rsp_t;

  typedef struct packed {
    logic if_on;
    logic rf_on;
    logic ref_on;
  } slp_power_t;

  typedef struct packed {
    slp_phase_t phase;
    logic [12:0] rcnt;
    logic [5:0] pcnt;
    logic [11:0] cyc;
    logic [6:0] pmeas;
    logic fast;
    logic pwr;
  } slp_loop_t;

endpackage

/* slp_ctrl_assertions.sv */
// Checker: port assertions of the loop control block
`timescale 1ns/1ps

module slp_ctrl_assertions
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bus and pins
  input slp_pkg::slp_apb_req_t apb_req,
  input slp_pkg::slp_apb_rsp_t apb_rsp,
  input wire logic powerdown_pin_n,
  input wire logic reference_input_pin,
  input wire logic [2:0] comp_limit_near,
  // Outputs watched
  input slp_pkg::slp_power_t power_ctl,
  input wire logic [2:0] loop_in_control,
  input wire logic [2:0] loop_settled,
  input wire logic lock_warning_n
);
  import slp_pkg::*;
  logic ref_ff;
  logic [7:0] edge_ff;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Reference rises while the first RF loop is powered and unlocked
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ref_ff <= 1'b0;
      edge_ff <= 8'h00;
    end
    else
    begin
      ref_ff <= reference_input_pin;
      if (!power_ctl.rf_on || loop_settled[0])
        edge_ff <= 8'h00;
      else if (reference_input_pin && !ref_ff && edge_ff != 8'hFF)
        edge_ff <= edge_ff + 8'h01;
    end
  end

  // Power, bus and loop timing relations
  pin_off_a: assert property (
    !powerdown_pin_n |=> !power_ctl.if_on && !power_ctl.rf_on)
    else $error("section on while pin low");
  ref_amp_a: assert property (
    power_ctl.ref_on == (power_ctl.if_on || power_ctl.rf_on))
    else $error("reference amplifier mismatch");
  any_state_a: assert property (
    apb_req.psel && apb_req.penable && apb_req.paddr == 8'h08
    |-> !apb_rsp.pslverr) else $error("power write refused");
  tune_len_a: assert property (
    $rose(loop_in_control[0]) |-> edge_ff >= 8'h0D)
    else $error("tuning ended early");
  settle_len_a: assert property (
    $rose(loop_settled[0]) |-> edge_ff >= 8'h28)
    else $error("settling ended early");
  lock_path_a: assert property (
    $rose(loop_settled[0]) |-> $past(loop_in_control[0]))
    else $error("lock without settling");
  warn_tune_a: assert property (
    (power_ctl.rf_on && !loop_in_control[0]) [*4] |-> !lock_warning_n)
    else $error("no warning while tuning");
  warn_near_a: assert property (
    (power_ctl.rf_on && comp_limit_near[0]) [*3] |-> !lock_warning_n)
    else $error("no warning near range limit");
endmodule

bind slp_ctrl slp_ctrl_assertions u_chk
(
  .clk, .rstn, .apb_req, .apb_rsp, .powerdown_pin_n,
  .reference_input_pin, .comp_limit_near, .power_ctl,
  .loop_in_control, .loop_settled, .lock_warning_n
);

/* slp_host.sv */
// Host model: APB master that programs the loop control
`timescale 1ns/1ps

module slp_host
(
  // Clock
  input wire logic clk,
  // APB master side
  output slp_pkg::slp_apb_req_t apb_req,
  input slp_pkg::slp_apb_rsp_t apb_rsp
);
  import slp_pkg::*;
  initial apb_req = '0;

  // One transfer; an idle bus shows junk so no stale value passes
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err,
    output logic tmo);
    int n;
    @(posedge clk);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (apb_rsp.pready !== 1'b1 && n < 64);
    tmo = apb_rsp.pready !== 1'b1;
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '{1'b0, 1'b0, ~wr, ~a, ~d};
  endtask
endmodule

/* test_slp_ctrl.sv */
// Testbench: loop control block against a bench model
`timescale 1ns/1ps

module test_slp_ctrl;
  import slp_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic pin_n = 1'b0;
  logic ref_in = 1'b0;
  logic [2:0] near = 3'h0;
  slp_apb_req_t req;
  slp_apb_rsp_t rsp;
  slp_power_t pwr;
  logic aux, lowb, vsel, lwn, irq, err, tmo, ifo, rfo;
  logic [1:0] g1, g2, gi;
  logic [5:0] gw;
  logic [2:0][3:0] rel;
  logic [2:0] ctl, setl;
  logic [31:0] rd;
  logic [31:0] seed = 32'hE42C502E;
  int n_fail = 0;
  int total_checks = 0;
  int n;

  // Clock, and a free reference at half the clock rate
  always #12.5 clk = ~clk;
  always @(posedge clk) ref_in <= ~ref_in;

  slp_host u_host (.clk, .apb_req(req), .apb_rsp(rsp));
  slp_ctrl u_dut
  (
    .clk, .rstn, .apb_req(req), .apb_rsp(rsp), .powerdown_pin_n(pin_n),
    .reference_input_pin(ref_in), .comp_limit_near(near),
    .aux_output_pin(aux), .power_ctl(pwr), .if_low_bias(lowb),
    .rf_vco_select(vsel), .rf1_pd_gain(g1), .rf2_pd_gain(g2),
    .if_pd_gain(gi), .pd_rel_gain(rel), .loop_in_control(ctl),
    .loop_settled(setl), .lock_warning_n(lwn), .irq
  );

  // Random source and gain choice from an N value
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [1:0] kp(input logic [13:0] v);
    return v < 14'h0800 ? 2'h0 : v < 14'h1000 ? 2'h1 :
      v < 14'h2000 ? 2'h2 : 2'h3;
  endfunction

  // Verdict, comparison and bus helpers
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    u_host.xfer(w, a, d, rd, err, tmo);
    if (tmo === 1'b1)
    begin
      n_fail++;
      test_done();
    end
  endtask
  function automatic logic cond(input int c);
    case (c)
      0: return ctl[0] === 1'b1;
      1: return setl[0] === 1'b1;
      2: return lwn === 1'b0;
      default: return setl === 3'h7;
    endcase
  endfunction
  task automatic wait_c(input int c);
    n = 0;
    while (!cond(c) && n < 9000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 9000)
    begin
      n_fail++;
      test_done();
    end
  endtask
  task automatic after2();
    @(posedge clk);
    @(negedge clk);
  endtask

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    pin_n <= 1'b1;
    @(negedge clk);
    chk({pwr, lwn, irq}, 5'h02);
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      gw = {kp(seed[13:0]), kp(seed[27:14]), 2'(k)};
      bus(1'b1, 8'h04, {26'h0, gw});
      @(negedge clk);
      chk({g1, g2, gi}, {gw[1:0], gw[3:2], gw[5:4]});
      chk(rel, {4'h8 >> gw[5:4], 4'h8 >> gw[3:2], 4'h8 >> gw[1:0]});
    end
    for (int i = 0; i < 16; i++)
    begin
      seed = lfsr(seed);
      @(posedge clk);
      pin_n <= i[3];
      bus(1'b1, 8'h00, {18'h0, 2'h3, 6'h0, seed[0], 1'b0, i[2], 3'h0});
      bus(1'b1, 8'h08, 32'(i[1:0]));
      bus(1'b0, 8'h08, 32'h0);
      chk(rd, 32'(i[1:0]));
      @(negedge clk);
      ifo = i[3] && (i[2] || i[1]);
      rfo = i[3] && (i[2] || i[0]);
      chk(pwr, {ifo, rfo, ifo || rfo});
      chk(lowb, seed[0]);
    end
    bus(1'b1, 8'h20, 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b1, 8'(8'h0C + 4 * (k % 2) + 12 * (k / 2)), 32'h1);
      after2();
      chk(vsel, 32'(k % 2));
    end
    wait_c(3);
    bus(1'b1, 8'h40, 32'hF);
    bus(1'b1, 8'h44, 32'h1);
    bus(1'b1, 8'h0C, 32'h800);
    wait_c(2);
    @(negedge clk);
    chk(aux, 1'b0);
    wait_c(0);
    chk(n >= 22 && n <= 25, 1'b1);
    wait_c(1);
    chk(n >= 53 && n <= 55, 1'b1);
    repeat (3) @(negedge clk);
    chk({lwn, aux, irq}, 3'h7);
    bus(1'b0, 8'h48, 32'h0);
    chk(rd, 32'h7F);
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h9);
    bus(1'b1, 8'h44, 32'h0);
    after2();
    chk(irq, 1'b0);
    bus(1'b1, 8'h44, 32'h1);
    after2();
    chk(irq, 1'b1);
    bus(1'b1, 8'h40, 32'hF);
    after2();
    chk(irq, 1'b0);
    @(posedge clk);
    near <= 3'h1;
    repeat (3) @(negedge clk);
    chk({lwn, aux}, 2'h0);
    @(posedge clk);
    near <= 3'h0;
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b1, 8'h00, {18'h0, 2'(k), 12'h008});
      repeat (3) @(negedge clk);
      chk(aux, k == 3);
    end
    // Halved reference: tuning takes twice as many clocks
    bus(1'b1, 8'h00, 32'h3048);
    bus(1'b1, 8'h0C, 32'h1);
    @(negedge clk);
    wait_c(0);
    chk(n >= 49 && n <= 52, 1'b1);
    bus(1'b0, 8'h24, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    test_done();
  end
endmodule
